// *** rtl/pmt_timer.v ***
// Five 8-bit period-match timers behind an AXI4-Lite register slave.
// Assumes one 40 MHz clock that also serves as the timer input clock,
// and an asynchronous active-low reset.
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "pmt_defs.vh"

module pmt_timer #(
    parameter LARGE_MEM = 1
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // PWM time base, one pulse per period match
    output wire [4:0] pwmTimeBase,
    // Shared interrupt register contents
    output reg [7:0] timerIrqFlags,
    output reg [7:0] timerIrqEnables,
    output reg [7:0] timerIrqPriority
);

    localparam NUM_INST = 5;
    localparam [14:0] IRQ_POS = `PMT_IRQ_POS;
    localparam [7:0] IRQ_MASK = (LARGE_MEM != 0) ?
        `PMT_IRQ_MASK_LARGE : `PMT_IRQ_MASK_SMALL;

    // ---------------------------------------------------------------
    // Write channel
    // ---------------------------------------------------------------
    reg awHave_q;
    reg wHave_q;
    reg [7:0] wrAddr_q;
    reg [7:0] wrData_q;
    reg wrByte_q;

    wire doWrite;
    wire wrMapped;
    wire [2:0] wrInst;
    wire [7:0] wrOfs;

    // Write happens once both address and data are held
    assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;

    // Instance in bits 6:4, register in 3:0
    assign wrInst = wrAddr_q[6:4];
    assign wrOfs = {4'h0, wrAddr_q[3:0]};

    // Address and data captured in either order
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            wrAddr_q <= 8'h00;
            wrData_q <= 8'h00;
            wrByte_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PMT_RESP_OKAY;
        end else begin
            // Readies pulse; valid waits
            s_axi_awready <= !awHave_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !wHave_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_q <= 1'b1;
                wrAddr_q <= {s_axi_awaddr[7:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_q <= 1'b1;
                wrData_q <= s_axi_wdata[7:0];
                wrByte_q <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            // Answer once both halves are in
            if (doWrite) begin
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrMapped ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Per-instance timers
    // ---------------------------------------------------------------
    wire [39:0] countVec;
    wire [39:0] controlVec;
    wire [39:0] periodVec;
    wire [4:0] flagSet;
    wire [4:0] matchVec;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_INST; gi = gi + 1) begin : gTimer
            localparam PRESENT = (gi < 3) || (LARGE_MEM != 0);
            reg [7:0] count_q;
            reg [7:0] control_q;
            reg [7:0] period_q;
            reg [3:0] preCnt_q;
            reg [3:0] postCnt_q;
            reg match_q;
            reg flagPulse_q;
            reg [3:0] preLimit;

            wire hit;
            wire tick;
            wire wrCount;
            wire wrControl;
            wire wrPeriod;

            // Absent timers ignore writes
            assign hit = doWrite && wrByte_q && PRESENT &&
                (wrInst == gi);
            assign wrCount = hit && (wrOfs == `PMT_OFS_COUNT);
            assign wrControl = hit && (wrOfs == `PMT_OFS_CONTROL);
            assign wrPeriod = hit && (wrOfs == `PMT_OFS_PERIOD);
            // [RL8] prescaled input tick
            assign tick = control_q[`PMT_CTL_RUN_BIT] &&
                (preCnt_q == preLimit);

            // Prescale select decode
            always @* begin
                case (control_q[`PMT_CTL_PRE_HI:`PMT_CTL_PRE_LO])
                    2'b00: preLimit = `PMT_PRE_DIV1;
                    2'b01: preLimit = `PMT_PRE_DIV4;
                    default: preLimit = `PMT_PRE_DIV16;
                endcase
            end

            // Count, prescaler, postscaler and registers
            always @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    count_q <= `PMT_RST_COUNT;
                    control_q <= `PMT_RST_CONTROL;
                    // [RL3] period starts at all ones
                    period_q <= `PMT_RST_PERIOD;
                    preCnt_q <= 4'h0;
                    postCnt_q <= 4'h0;
                    match_q <= 1'b0;
                    flagPulse_q <= 1'b0;
                end else begin
                    match_q <= 1'b0;
                    flagPulse_q <= 1'b0;
                    if (control_q[`PMT_CTL_RUN_BIT]) begin
                        preCnt_q <= tick ? 4'h0 : preCnt_q + 4'h1;
                    end
                    if (tick) begin
                        // [RL1] wrap to zero after match
                        if (count_q == period_q) begin
                            count_q <= 8'h00;
                            match_q <= 1'b1;
                            // [RL8] postscale matches to flag
                            if (postCnt_q ==
                                control_q[`PMT_CTL_POST_HI:`PMT_CTL_POST_LO])
                            begin
                                postCnt_q <= 4'h0;
                                flagPulse_q <= 1'b1;
                            end else begin
                                postCnt_q <= postCnt_q + 4'h1;
                            end
                        end else begin
                            count_q <= count_q + 8'h01;
                        end
                    end
                    // Writes to count or control clear both scalers
                    if (wrCount || wrControl) begin
                        preCnt_q <= 4'h0;
                        postCnt_q <= 4'h0;
                    end
                    if (wrCount) begin
                        count_q <= wrData_q;
                    end
                    // [RL5] bit 7 is never stored
                    if (wrControl) begin
                        control_q <= wrData_q & `PMT_CTL_WRITE_MASK;
                    end
                    // [RL2] period written at any time
                    if (wrPeriod) begin
                        period_q <= wrData_q;
                    end
                end
            end

            assign countVec[gi*8 +: 8] = count_q;
            assign controlVec[gi*8 +: 8] = control_q;
            assign periodVec[gi*8 +: 8] = period_q;
            assign flagSet[gi] = flagPulse_q;
            // [RL4] unscaled match goes only to PWM time base
            assign matchVec[gi] = match_q;
        end
    endgenerate

    // Taken ahead of the postscaler
    assign pwmTimeBase = matchVec;

    // ---------------------------------------------------------------
    // Shared interrupt registers
    // ---------------------------------------------------------------
    reg [7:0] flagSetBits;
    integer k;

    // [RL6] spread instance events onto their bit positions
    always @* begin
        flagSetBits = 8'h00;
        for (k = 0; k < NUM_INST; k = k + 1) begin
            flagSetBits[IRQ_POS[k*3 +: 3]] = flagSet[k];
        end
    end

    // Flags, enables and priorities; a set wins over a clear
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            timerIrqFlags <= `PMT_RST_IRQ;
            timerIrqEnables <= `PMT_RST_IRQ;
            timerIrqPriority <= `PMT_RST_IRQ;
        end else begin
            // [RL7] absent positions stay zero
            if (doWrite && wrByte_q &&
                (wrAddr_q == `PMT_OFS_IRQ_FLAGS)) begin
                timerIrqFlags <= (wrData_q | flagSetBits) & IRQ_MASK;
            end else begin
                timerIrqFlags <= (timerIrqFlags | flagSetBits) & IRQ_MASK;
            end
            if (doWrite && wrByte_q &&
                (wrAddr_q == `PMT_OFS_IRQ_ENABLES)) begin
                timerIrqEnables <= wrData_q & IRQ_MASK;
            end
            if (doWrite && wrByte_q &&
                (wrAddr_q == `PMT_OFS_IRQ_PRIORITY)) begin
                timerIrqPriority <= wrData_q & IRQ_MASK;
            end
        end
    end

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    // Unlisted addresses answer SLVERR
    function mapped;
        input [7:0] addr;
        reg [7:0] ofs;
        begin
            ofs = {4'h0, addr[3:0]};
            if ((addr == `PMT_OFS_IRQ_FLAGS) ||
                (addr == `PMT_OFS_IRQ_ENABLES) ||
                (addr == `PMT_OFS_IRQ_PRIORITY)) begin
                mapped = 1'b1;
            end else if (addr <= (`PMT_OFS_LAST_INST + `PMT_OFS_PERIOD)) begin
                mapped = (ofs == `PMT_OFS_COUNT) ||
                    (ofs == `PMT_OFS_CONTROL) ||
                    (ofs == `PMT_OFS_PERIOD);
            end else begin
                mapped = 1'b0;
            end
        end
    endfunction

    assign wrMapped = mapped(wrAddr_q);

    // ---------------------------------------------------------------
    // Read channel
    // ---------------------------------------------------------------
    reg [7:0] rdByte;

    wire [7:0] rdAddr;
    wire [2:0] rdInst;
    wire [7:0] rdOfs;
    wire rdPresent;

    assign rdAddr = {s_axi_araddr[7:2], 2'b00};
    assign rdInst = rdAddr[6:4];
    assign rdOfs = {4'h0, rdAddr[3:0]};

    // Upper two timers on large variant only
    assign rdPresent = (rdInst < 3'h3) || (LARGE_MEM != 0);

    // Read data select; absent instances read zero
    always @* begin
        rdByte = 8'h00;
        if (rdAddr == `PMT_OFS_IRQ_FLAGS) begin
            rdByte = timerIrqFlags;
        end else if (rdAddr == `PMT_OFS_IRQ_ENABLES) begin
            rdByte = timerIrqEnables;
        end else if (rdAddr == `PMT_OFS_IRQ_PRIORITY) begin
            rdByte = timerIrqPriority;
        end else if (rdPresent && (rdInst < 3'h5)) begin
            case (rdOfs)
                `PMT_OFS_COUNT: rdByte = countVec[rdInst*8 +: 8];
                `PMT_OFS_CONTROL: rdByte = controlVec[rdInst*8 +: 8];
                `PMT_OFS_PERIOD: rdByte = periodVec[rdInst*8 +: 8];
                default: rdByte = 8'h00;
            endcase
        end
    end

    // Single outstanding read, answered the cycle after the address
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PMT_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rdByte};
                s_axi_rresp <= mapped(rdAddr) ? `PMT_RESP_OKAY :
                    `PMT_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // pmt_timer

// *** rtl/pmt_defs.vh ***
// Constants for the five-instance 8-bit period-match timer block.
// Assumes inclusion by the timer top level and the bench; definitions only.
//
// Functional notes
// [RL1] Count up from zero, wrap after matching period.
// [RL2] Each instance has a readable, writable period register.
// [RL3] Period registers reset to all ones.
// [RL4] Unscaled match feeds only the PWM time base.
// [RL5] Control: bit7 zero, postscale, run, prescale fields.
// [RL6] Interrupt bits at positions 0, 2, 4, 5, 6.
// [RL7] Small variant: timers 10 and 12 read zero.
// [RL8] Prescale input clock, postscale matches, then set flag.
`ifndef PMT_DEFS_VH
`define PMT_DEFS_VH

// ---------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------
`define PMT_ADDR_W 8
`define PMT_INST_STRIDE 8'h10
`define PMT_OFS_COUNT 8'h00
`define PMT_OFS_CONTROL 8'h04
`define PMT_OFS_PERIOD 8'h08
`define PMT_OFS_LAST_INST 8'h40
`define PMT_OFS_IRQ_FLAGS 8'h50
`define PMT_OFS_IRQ_ENABLES 8'h54
`define PMT_OFS_IRQ_PRIORITY 8'h58

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define PMT_CTL_UNUSED_BIT 7
`define PMT_CTL_POST_HI 6
`define PMT_CTL_POST_LO 3
`define PMT_CTL_RUN_BIT 2
`define PMT_CTL_PRE_HI 1
`define PMT_CTL_PRE_LO 0
`define PMT_CTL_WRITE_MASK 8'h7f

// ---------------------------------------------------------------
// Prescale limits (cycles minus one per tick)
// ---------------------------------------------------------------
`define PMT_PRE_DIV1 4'h0
`define PMT_PRE_DIV4 4'h3
`define PMT_PRE_DIV16 4'hf

// ---------------------------------------------------------------
// Shared interrupt bit positions, packed 3 bits per instance
// ---------------------------------------------------------------
`define PMT_IRQ_POS {3'h6, 3'h5, 3'h4, 3'h2, 3'h0}
`define PMT_IRQ_MASK_LARGE 8'h75
`define PMT_IRQ_MASK_SMALL 8'h15

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define PMT_RST_COUNT 8'h00
`define PMT_RST_CONTROL 8'h00
`define PMT_RST_PERIOD 8'hff
`define PMT_RST_IRQ 8'h00

// ---------------------------------------------------------------
// Bus answers
// ---------------------------------------------------------------
`define PMT_RESP_OKAY 2'h0
`define PMT_RESP_SLVERR 2'h2

`endif

// *** bench/pmt_timer_monitor.sv ***
// Checker for the period-match timer: bus handshakes and timer outputs.
// Assumes binding to every pmt_timer instance with its LARGE_MEM value.
`timescale 1ns/100ps

module pmt_timer_monitor #(
    parameter LARGE_MEM = 1
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Register bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // Timer outputs
    input wire [4:0] pwmTimeBase,
    input wire [7:0] timerIrqFlags
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // Transfer steps
    // ------------------------------------------------------------
    sequence writeTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence readTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence flagRise;
        $rose(timerIrqFlags[0]) && !$rose(s_axi_bvalid);
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_write_answered: assert property (
        writeTaken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_read_answered: assert property (
        readTaken |=> s_axi_rvalid)
        else $error("read data missing");
    a_bresp_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rdata_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_flag_spare_zero: assert property (
        (timerIrqFlags & 8'h8a) == 8'h00)
        else $error("flag set outside timer positions");
    a_small_flag_zero: assert property (
        LARGE_MEM == 0 |-> timerIrqFlags[6:5] == 2'h0)
        else $error("absent timer flag set");
    a_small_pulse_zero: assert property (
        LARGE_MEM == 0 |-> pwmTimeBase[4:3] == 2'h0)
        else $error("absent timer pulses");
    a_flag_after_wrap: assert property (
        flagRise |-> pwmTimeBase[0] || $past(pwmTimeBase[0])
            || $past(pwmTimeBase[0], 2))
        else $error("flag set without a wrap");
endmodule // pmt_timer_monitor

bind pmt_timer pmt_timer_monitor #(.LARGE_MEM(LARGE_MEM)) i_mon (
    .core_clk(core_clk), .reset_n(reset_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pwmTimeBase(pwmTimeBase), .timerIrqFlags(timerIrqFlags)
);

// *** bench/pmt_pwm_model.sv ***
// PWM stage model that takes the timers' time base pulses.
// Assumes the timer clock and reset; reports pulse counts and spacing.
`timescale 1ns/100ps

module pmt_pwm_model (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Time base from the timers
    input wire [4:0] pwmTimeBase,
    // Pulse count and last spacing per timer
    output logic [4:0][15:0] cntQ,
    output logic [4:0][15:0] gapQ
);
    logic [15:0] cycQ;
    logic [4:0][15:0] lastQ;

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cycQ <= 16'h0000;
            cntQ <= '0;
            gapQ <= '0;
            lastQ <= '0;
        end else begin
            cycQ <= cycQ + 16'h0001;
            for (int i = 0; i < 5; i++) begin
                if (pwmTimeBase[i]) begin
                    cntQ[i] <= cntQ[i] + 16'h0001;
                    gapQ[i] <= cycQ - lastQ[i]; // Cycles between wraps
                    lastQ[i] <= cycQ;
                end
            end
        end
    end
endmodule // pmt_pwm_model

// *** bench/testbench.sv ***
// Self-checking bench: full and small timer variants on one register bus.
// Assumes the design header for addresses, fields and reset values.
`timescale 1ns/100ps
`include "pmt_defs.vh"

module testbench;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, smRdata;
    logic [4:0] pwmTimeBase, smPulse;
    logic [7:0] timerIrqFlags, timerIrqEnables, timerIrqPriority, smFlags;
    logic [4:0][15:0] pulseCnt, gapCyc;
    logic [7:0] d, s, b;
    logic [1:0] r;
    int errCount = 0;
    int compares = 0;
    int div;

    // Clock at 40 MHz
    always #12.5 core_clk = ~core_clk;

    pmt_timer #(.LARGE_MEM(1)) i_pmt_timer (
        .core_clk(core_clk), .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pwmTimeBase(pwmTimeBase),
        .timerIrqFlags(timerIrqFlags), .timerIrqEnables(timerIrqEnables),
        .timerIrqPriority(timerIrqPriority));

    // Small variant sees the same bus traffic
    pmt_timer #(.LARGE_MEM(0)) i_pmt_timer_small (
        .core_clk(core_clk), .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
        .s_axi_rdata(smRdata), .s_axi_rresp(), .s_axi_rvalid(),
        .s_axi_rready(s_axi_rready), .pwmTimeBase(smPulse),
        .timerIrqFlags(smFlags), .timerIrqEnables(),
        .timerIrqPriority());

    pmt_pwm_model i_pmt_pwm_model (.core_clk(core_clk), .reset_n(reset_n),
        .pwmTimeBase(pwmTimeBase), .cntQ(pulseCnt), .gapQ(gapCyc));

    // ------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [7:0] v,
            output logic [1:0] resp);
        int n;
        resp = 2'h3;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h000000, v};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        check("write answered", n < 50, 32'h1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [1:0] resp;
        axi_write(a, v, resp);
        check("write resp", resp, `PMT_RESP_OKAY);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v,
            output logic [1:0] resp, output logic [7:0] sv);
        int n;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                v = s_axi_rdata[7:0];
                sv = smRdata[7:0];
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        check("read answered", n < 50, 32'h1);
    endtask

    task automatic wait_pulses(input int i, input int n);
        logic [15:0] start;
        start = pulseCnt[i];
        for (int k = 0; k < 3000 && pulseCnt[i] < start + n; k++)
            @(posedge core_clk);
        check("wraps seen", pulseCnt[i] >= start + n, 32'h1);
    endtask

    task final_report;
        $display("compares %0d errCount %0d", compares, errCount);
        if (errCount == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Watchdog
    initial begin
        #(25 * 40000);
        errCount++;
        final_report;
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        // Reset values, read/write and control layout of each timer
        for (int i = 0; i < 5; i++) begin
            b = `PMT_INST_STRIDE * i[7:0];
            rd(b + `PMT_OFS_PERIOD, d, r, s);
            check("period reset", d, `PMT_RST_PERIOD);
            check("small period", s, i < 3 ? 8'hff : 8'h00);
            rd(b + `PMT_OFS_CONTROL, d, r, s);
            check("control reset", d, `PMT_RST_CONTROL);
            wr(b + `PMT_OFS_PERIOD, 8'h5a);
            rd(b + `PMT_OFS_PERIOD, d, r, s);
            check("period rw", d, 8'h5a);
            wr(b + `PMT_OFS_CONTROL, 8'hf8);
            rd(b + `PMT_OFS_CONTROL, d, r, s);
            check("control fields", d, 8'h78);
        end
        // Unmapped address answers with an error
        axi_write(8'h60, 8'h11, r);
        check("unmapped bresp", r, `PMT_RESP_SLVERR);
        rd(8'h60, d, r, s);
        check("unmapped rresp", r, `PMT_RESP_SLVERR);
        check("unmapped data", d, 8'h00);
        // Every timer wraps at its own period, flag on each wrap
        for (int i = 0; i < 5; i++) begin
            wr(`PMT_INST_STRIDE * i[7:0] + `PMT_OFS_PERIOD, 8'h03 + i[7:0]);
            wr(`PMT_INST_STRIDE * i[7:0] + `PMT_OFS_CONTROL, 8'h04);
        end
        for (int i = 0; i < 5; i++) begin
            wait_pulses(i, 3);
            check("wrap gap", gapCyc[i], 4 + i);
        end
        rd(`PMT_OFS_IRQ_FLAGS, d, r, s);
        check("flags", d, `PMT_IRQ_MASK_LARGE);
        check("small flags", s, `PMT_IRQ_MASK_SMALL);
        check("flag port", timerIrqFlags, `PMT_IRQ_MASK_LARGE);
        // Enable and priority hold only the timer positions
        wr(`PMT_OFS_IRQ_ENABLES, 8'hff);
        wr(`PMT_OFS_IRQ_PRIORITY, 8'hff);
        rd(`PMT_OFS_IRQ_ENABLES, d, r, s);
        check("enables", d, `PMT_IRQ_MASK_LARGE);
        check("enable port", timerIrqEnables, `PMT_IRQ_MASK_LARGE);
        check("priority port", timerIrqPriority, `PMT_IRQ_MASK_LARGE);
        // Stopped timers leave cleared flags clear
        for (int i = 0; i < 5; i++)
            wr(`PMT_INST_STRIDE * i[7:0] + `PMT_OFS_CONTROL, 8'h00);
        wr(`PMT_OFS_IRQ_FLAGS, 8'h00);
        rd(`PMT_OFS_IRQ_FLAGS, d, r, s);
        check("flags cleared", d, 8'h00);
        // Count reads back; a write with strobe low is dropped
        wr(`PMT_OFS_COUNT, 8'h01);
        s_axi_wstrb <= 4'h0;
        wr(`PMT_OFS_COUNT, 8'h33);
        s_axi_wstrb <= 4'hf;
        rd(`PMT_OFS_COUNT, d, r, s);
        check("count rw", d, 8'h01);
        // Every prescale code on the first timer
        wr(`PMT_OFS_PERIOD, 8'h02);
        for (int p = 0; p < 4; p++) begin
            div = p == 0 ? 1 : (p == 1 ? 4 : 16);
            wr(`PMT_OFS_CONTROL, 8'h04 | p[7:0]);
            wait_pulses(0, 3);
            check("prescaled gap", gapCyc[0], 3 * div);
        end
        // Postscale of four: flag waits for the fourth wrap
        wr(`PMT_OFS_CONTROL, 8'h00);
        wr(`PMT_OFS_IRQ_FLAGS, 8'h00);
        wr(`PMT_OFS_CONTROL, 8'h1c);
        wait_pulses(0, 2);
        rd(`PMT_OFS_IRQ_FLAGS, d, r, s);
        check("flag early", d[0], 1'b0);
        wait_pulses(0, 3);
        rd(`PMT_OFS_IRQ_FLAGS, d, r, s);
        check("flag set", d[0], 1'b1);
        final_report;
    end
endmodule // testbench
